// [core/axcec_checker.sv]
`timescale 1ns/10ps
// What this block does
// - Speed teaching while the axis runs is rejected with code 463.
// - Nonvolatile teaching while the axis runs is rejected with code 464.
// - Teaching step number above 150 gives code 465.
// - Multi teaching list selector other than 0 or 1 gives code 466.
// - Multi teaching method selector other than 0 or 1 gives code 467.
// - Parameter teaching while the axis runs is rejected with code 471.
// - Operating data teaching while the axis runs is rejected with code 472.
// - Teaching a non-teachable item gives code 473.
// - Teaching value outside the item's range gives code 475.
// - Emergency stop latches code 481 until cause gone and clear issued.
// - Upper hard limit latches 492; jog out, then clear.
// - Lower hard limit latches 493; jog out, then clear.
// - Passing soft upper limit latches 501; back in range, then clear.
// - Passing soft lower limit latches 502; back in range, then clear.
// - Unknown command code gives code 511.
// - Auxiliary step number outside 1 to 150 gives code 512.
// - Direction reversal in continuous mode is refused with code 513.
// - Encoder preset naming an encoder other than 0 gives code 531.
// - Encoder preset while its main axis operates gives code 532.
// - Encoder preset value outside encoder min and max gives code 534.
// - Teaching array count outside 1 to 16 gives code 462.
module axcec_checker (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [axcec_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [axcec_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [axcec_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [axcec_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic estopIn,
   input wire logic hardUpperIn,
   input wire logic hardLowerIn,
   input wire logic axisRunning,
   input wire logic contMode,
   input wire logic curDirection,
   input wire logic encAxisBusy,
   input wire logic [axcec_pkg::DATA_W-1:0] position,
   output logic [axcec_pkg::CODE_W-1:0] errCode,
   output logic errActive,
   output logic faultStop,
   output logic cmdAccept,
   output logic [7:0] acceptedCmd
);
   logic [2:0] pins;
   logic awHeld, wHeld;
   logic [axcec_pkg::ADDR_W-1:0] awAddrQ;
   logic [axcec_pkg::DATA_W-1:0] wDataQ;
   logic [3:0] wStrbQ;
   logic next_awHeld, next_wHeld, next_awready, next_wready, next_bvalid;
   logic [axcec_pkg::ADDR_W-1:0] next_awAddrQ;
   logic [axcec_pkg::DATA_W-1:0] next_wDataQ;
   logic [3:0] next_wStrbQ;
   logic [1:0] next_bresp;
   logic awTaken, wTaken, doWrite, wrMapped;
   logic [axcec_pkg::ADDR_W-1:0] wrAddr;
   logic [axcec_pkg::DATA_W-1:0] wrData;
   logic [3:0] wrStrb;
   logic next_arready, next_rvalid;
   logic [axcec_pkg::DATA_W-1:0] next_rdata;
   logic [1:0] next_rresp;
   logic [7:0] cmdReg;
   logic [axcec_pkg::DATA_W-1:0] argReg, selReg, valueReg;
   logic [axcec_pkg::DATA_W-1:0] softUp, softLo, encMax, encMin;
   logic [7:0] next_cmdReg;
   logic [axcec_pkg::DATA_W-1:0] next_argReg, next_selReg, next_valueReg;
   logic [axcec_pkg::DATA_W-1:0] next_softUp, next_softLo, next_encMax, next_encMin;
   logic cmdPend, next_cmdPend;
   logic [axcec_pkg::CODE_W-1:0] cmdErr, next_cmdErr, chkErr, next_errCode;
   logic [axcec_pkg::FAULT_W-1:0] faults, next_faults, cause;
   logic next_errActive, next_faultStop, next_cmdAccept;
   logic [7:0] next_acceptedCmd, acceptCount, next_acceptCount;
   logic [7:0] step, list, method, item, count;
   logic [axcec_pkg::DATA_W-1:0] itemMax;
   logic stepAuxOk;

   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic isMapped(input logic [axcec_pkg::ADDR_W-1:0] a);
      logic [axcec_pkg::ADDR_W-1:0] w;
      w = {a[axcec_pkg::ADDR_W-1:2], 2'h0};
      return (w <= axcec_pkg::REG_STATUS);
   endfunction

   axcec_sync #(
      .WIDTH(3)
   ) pinSync (
      .clock(clock),
      .rst_n(rst_n),
      .async({hardLowerIn, hardUpperIn, estopIn}),
      .synced(pins)
   );

   // write channel: address and data taken in either order
   always_comb begin
      awTaken = awvalid && awready;
      wTaken = wvalid && wready;
      doWrite = (awHeld || awTaken) && (wHeld || wTaken);
      wrAddr = awHeld ? awAddrQ : awaddr;
      wrData = wHeld ? wDataQ : wdata;
      wrStrb = wHeld ? wStrbQ : wstrb;
      wrAddr = {wrAddr[axcec_pkg::ADDR_W-1:2], 2'h0};
      wrMapped = isMapped(wrAddr);
      next_awHeld = (awHeld || awTaken) && !doWrite;
      next_wHeld = (wHeld || wTaken) && !doWrite;
      next_awAddrQ = awTaken ? awaddr : awAddrQ;
      next_wDataQ = wTaken ? wdata : wDataQ;
      next_wStrbQ = wTaken ? wstrb : wStrbQ;
      next_bvalid = doWrite || (bvalid && !bready);
      next_bresp = bresp;
      if (doWrite) begin
         next_bresp = wrMapped ? axcec_pkg::RESP_OKAY : axcec_pkg::RESP_SLVERR;
      end
      next_awready = !next_bvalid && !next_awHeld;
      next_wready = !next_bvalid && !next_wHeld;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddrQ <= '0;
         wDataQ <= '0;
         wStrbQ <= '0;
         bvalid <= 1'b0;
         bresp <= axcec_pkg::RESP_OKAY;
         awready <= 1'b0;
         wready <= 1'b0;
      end else begin
         awHeld <= next_awHeld;
         wHeld <= next_wHeld;
         awAddrQ <= next_awAddrQ;
         wDataQ <= next_wDataQ;
         wStrbQ <= next_wStrbQ;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         awready <= next_awready;
         wready <= next_wready;
      end
   end

   // read channel
   always_comb begin
      logic [axcec_pkg::ADDR_W-1:0] ra;
      ra = {araddr[axcec_pkg::ADDR_W-1:2], 2'h0};
      next_rvalid = rvalid && !rready;
      next_rdata = rdata;
      next_rresp = rresp;
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp = isMapped(ra) ? axcec_pkg::RESP_OKAY : axcec_pkg::RESP_SLVERR;
         case (ra)
            axcec_pkg::REG_CMD: next_rdata = {24'h000000, cmdReg};
            axcec_pkg::REG_ARG: next_rdata = argReg;
            axcec_pkg::REG_SEL: next_rdata = selReg;
            axcec_pkg::REG_VALUE: next_rdata = valueReg;
            axcec_pkg::REG_SOFT_UP: next_rdata = softUp;
            axcec_pkg::REG_SOFT_LO: next_rdata = softLo;
            axcec_pkg::REG_ENC_MAX: next_rdata = encMax;
            axcec_pkg::REG_ENC_MIN: next_rdata = encMin;
            axcec_pkg::REG_ERROR: begin
               next_rdata = '0;
               next_rdata[axcec_pkg::CODE_W-1:0] = errCode;
               next_rdata[axcec_pkg::ERR_FAULT_LSB +: axcec_pkg::FAULT_W] = faults;
            end
            axcec_pkg::REG_STATUS: begin
               next_rdata = '0;
               next_rdata[0] = axisRunning;
               next_rdata[1] = contMode;
               next_rdata[2] = curDirection;
               next_rdata[3] = encAxisBusy;
               next_rdata[6:4] = pins;
               next_rdata[axcec_pkg::ST_COUNT_LSB +: 8] = acceptCount;
            end
            default: next_rdata = '0;
         endcase
      end
      next_arready = !next_rvalid;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= axcec_pkg::RESP_OKAY;
         arready <= 1'b0;
      end else begin
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
         arready <= next_arready;
      end
   end

   // software registers; a write to the command register queues a check
   always_comb begin
      next_cmdReg = cmdReg;
      next_argReg = argReg;
      next_selReg = selReg;
      next_valueReg = valueReg;
      next_softUp = softUp;
      next_softLo = softLo;
      next_encMax = encMax;
      next_encMin = encMin;
      next_cmdPend = 1'b0;
      if (doWrite) begin
         case (wrAddr)
            axcec_pkg::REG_CMD: begin
               next_cmdReg = wrStrb[0] ? wrData[7:0] : cmdReg;
               next_cmdPend = wrStrb[0];
            end
            axcec_pkg::REG_ARG: next_argReg = mergeBytes(argReg, wrData, wrStrb);
            axcec_pkg::REG_SEL: next_selReg = mergeBytes(selReg, wrData, wrStrb);
            axcec_pkg::REG_VALUE: next_valueReg = mergeBytes(valueReg, wrData, wrStrb);
            axcec_pkg::REG_SOFT_UP: next_softUp = mergeBytes(softUp, wrData, wrStrb);
            axcec_pkg::REG_SOFT_LO: next_softLo = mergeBytes(softLo, wrData, wrStrb);
            axcec_pkg::REG_ENC_MAX: next_encMax = mergeBytes(encMax, wrData, wrStrb);
            axcec_pkg::REG_ENC_MIN: next_encMin = mergeBytes(encMin, wrData, wrStrb);
            default: next_cmdPend = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cmdReg <= '0;
         argReg <= axcec_pkg::RST_ZERO;
         selReg <= axcec_pkg::RST_ZERO;
         valueReg <= axcec_pkg::RST_ZERO;
         softUp <= axcec_pkg::RST_POS_MAX;
         softLo <= axcec_pkg::RST_POS_MIN;
         encMax <= axcec_pkg::RST_POS_MAX;
         encMin <= axcec_pkg::RST_POS_MIN;
         cmdPend <= 1'b0;
      end else begin
         cmdReg <= next_cmdReg;
         argReg <= next_argReg;
         selReg <= next_selReg;
         valueReg <= next_valueReg;
         softUp <= next_softUp;
         softLo <= next_softLo;
         encMax <= next_encMax;
         encMin <= next_encMin;
         cmdPend <= next_cmdPend;
      end
   end

   // command checks, first failing check gives the code
   always_comb begin
      step = argReg[7:0];
      list = selReg[axcec_pkg::SEL_LIST_LSB +: 8];
      method = selReg[axcec_pkg::SEL_METHOD_LSB +: 8];
      item = selReg[axcec_pkg::SEL_ITEM_LSB +: 8];
      count = selReg[axcec_pkg::SEL_COUNT_LSB +: 8];
      itemMax = axcec_pkg::ITEM_MAX_TBL[item[2:0]*axcec_pkg::DATA_W +: axcec_pkg::DATA_W];
      stepAuxOk = (step >= axcec_pkg::STEP_MIN) && (step <= axcec_pkg::STEP_MAX);
      chkErr = axcec_pkg::ERR_NONE;
      case (cmdReg)
         axcec_pkg::CMD_SPEED_TEACH: begin
            if (axisRunning) chkErr = axcec_pkg::ERR_SPEED_RUN;
            else if (step > axcec_pkg::STEP_MAX) chkErr = axcec_pkg::ERR_TEACH_STEP;
         end
         axcec_pkg::CMD_ROM_TEACH: begin
            if (axisRunning) chkErr = axcec_pkg::ERR_ROM_RUN;
            else if (step > axcec_pkg::STEP_MAX) chkErr = axcec_pkg::ERR_TEACH_STEP;
         end
         axcec_pkg::CMD_MULTI_TEACH: begin
            if (step > axcec_pkg::STEP_MAX) chkErr = axcec_pkg::ERR_TEACH_STEP;
            else if (list > axcec_pkg::SEL_MAX) chkErr = axcec_pkg::ERR_LIST;
            else if (method > axcec_pkg::SEL_MAX) chkErr = axcec_pkg::ERR_METHOD;
         end
         axcec_pkg::CMD_PARAM_TEACH, axcec_pkg::CMD_OPDATA_TEACH: begin
            if (axisRunning) begin
               chkErr = (cmdReg == axcec_pkg::CMD_PARAM_TEACH) ?
                        axcec_pkg::ERR_PARAM_RUN : axcec_pkg::ERR_OPDATA_RUN;
            end else if (item >= axcec_pkg::ITEM_COUNT) begin
               chkErr = axcec_pkg::ERR_ITEM;
            end else if (valueReg > itemMax) begin
               chkErr = axcec_pkg::ERR_ITEM_RANGE;
            end
         end
         axcec_pkg::CMD_DIR_CHANGE: begin
            if (!stepAuxOk) chkErr = axcec_pkg::ERR_AUX_STEP;
            else if (contMode && (argReg[axcec_pkg::ARG_DIR_BIT] != curDirection)) begin
               chkErr = axcec_pkg::ERR_DIR_CONT;
            end
         end
         axcec_pkg::CMD_STEP_SELECT: begin
            if (!stepAuxOk) chkErr = axcec_pkg::ERR_AUX_STEP;
         end
         axcec_pkg::CMD_ENC_PRESET: begin
            if (step != axcec_pkg::ENC_NUMBER) chkErr = axcec_pkg::ERR_ENC_NUM;
            else if (encAxisBusy) chkErr = axcec_pkg::ERR_ENC_BUSY;
            else if ($signed(valueReg) < $signed(encMin) ||
                     $signed(valueReg) > $signed(encMax)) begin
               chkErr = axcec_pkg::ERR_ENC_RANGE;
            end
         end
         axcec_pkg::CMD_TEACH_ARRAY: begin
            if (count < axcec_pkg::ARRAY_MIN || count > axcec_pkg::ARRAY_MAX) begin
               chkErr = axcec_pkg::ERR_ARRAY_COUNT;
            end
         end
         axcec_pkg::CMD_ERROR_CLEAR: chkErr = axcec_pkg::ERR_NONE;
         default: chkErr = axcec_pkg::ERR_BAD_CMD;
      endcase
   end

   // latched faults and reported code
   always_comb begin
      cause = '0;
      cause[axcec_pkg::F_ESTOP] = pins[0];
      cause[axcec_pkg::F_HARD_UP] = pins[1];
      cause[axcec_pkg::F_HARD_LO] = pins[2];
      cause[axcec_pkg::F_SOFT_UP] = $signed(position) > $signed(softUp);
      cause[axcec_pkg::F_SOFT_LO] = $signed(position) < $signed(softLo);
      next_faults = faults;
      next_cmdErr = cmdErr;
      next_cmdAccept = 1'b0;
      next_acceptedCmd = acceptedCmd;
      next_acceptCount = acceptCount;
      if (cmdPend) begin
         if (cmdReg == axcec_pkg::CMD_ERROR_CLEAR) begin
            next_faults = '0;
            next_cmdErr = axcec_pkg::ERR_NONE;
         end else if (chkErr != axcec_pkg::ERR_NONE) begin
            next_cmdErr = chkErr;
         end else begin
            next_cmdAccept = 1'b1;
            next_acceptedCmd = cmdReg;
            next_acceptCount = acceptCount + 8'h01;
         end
      end
      // a cause still present survives the clear
      next_faults = next_faults | cause;
      if (next_faults[axcec_pkg::F_ESTOP]) next_errCode = axcec_pkg::ERR_ESTOP;
      else if (next_faults[axcec_pkg::F_HARD_UP]) next_errCode = axcec_pkg::ERR_HARD_UP;
      else if (next_faults[axcec_pkg::F_HARD_LO]) next_errCode = axcec_pkg::ERR_HARD_LO;
      else if (next_faults[axcec_pkg::F_SOFT_UP]) next_errCode = axcec_pkg::ERR_SOFT_UP;
      else if (next_faults[axcec_pkg::F_SOFT_LO]) next_errCode = axcec_pkg::ERR_SOFT_LO;
      else next_errCode = next_cmdErr;
      next_errActive = next_errCode != axcec_pkg::ERR_NONE;
      next_faultStop = |next_faults;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         faults <= '0;
         cmdErr <= axcec_pkg::ERR_NONE;
         errCode <= axcec_pkg::ERR_NONE;
         errActive <= 1'b0;
         faultStop <= 1'b0;
         cmdAccept <= 1'b0;
         acceptedCmd <= '0;
         acceptCount <= '0;
      end else begin
         faults <= next_faults;
         cmdErr <= next_cmdErr;
         errCode <= next_errCode;
         errActive <= next_errActive;
         faultStop <= next_faultStop;
         cmdAccept <= next_cmdAccept;
         acceptedCmd <= next_acceptedCmd;
         acceptCount <= next_acceptCount;
      end
   end
endmodule

// [core/axcec_pkg.sv]
package axcec_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;
   localparam int CODE_W = 10;
   localparam int FAULT_W = 5;

   // register byte offsets
   localparam logic [ADDR_W-1:0] REG_CMD = 6'h00;
   localparam logic [ADDR_W-1:0] REG_ARG = 6'h04;
   localparam logic [ADDR_W-1:0] REG_SEL = 6'h08;
   localparam logic [ADDR_W-1:0] REG_VALUE = 6'h0C;
   localparam logic [ADDR_W-1:0] REG_SOFT_UP = 6'h10;
   localparam logic [ADDR_W-1:0] REG_SOFT_LO = 6'h14;
   localparam logic [ADDR_W-1:0] REG_ENC_MAX = 6'h18;
   localparam logic [ADDR_W-1:0] REG_ENC_MIN = 6'h1C;
   localparam logic [ADDR_W-1:0] REG_ERROR = 6'h20;
   localparam logic [ADDR_W-1:0] REG_STATUS = 6'h24;

   // field positions
   localparam int ARG_DIR_BIT = 8;
   localparam int SEL_LIST_LSB = 0;
   localparam int SEL_METHOD_LSB = 8;
   localparam int SEL_ITEM_LSB = 16;
   localparam int SEL_COUNT_LSB = 24;
   localparam int ERR_FAULT_LSB = 16;
   localparam int ST_COUNT_LSB = 8;

   // reset values
   localparam logic [DATA_W-1:0] RST_ZERO = 32'h00000000;
   localparam logic [DATA_W-1:0] RST_POS_MAX = 32'h7FFFFFFF;
   localparam logic [DATA_W-1:0] RST_POS_MIN = 32'h80000000;

   // command codes
   localparam logic [7:0] CMD_SPEED_TEACH = 8'h01;
   localparam logic [7:0] CMD_ROM_TEACH = 8'h02;
   localparam logic [7:0] CMD_MULTI_TEACH = 8'h03;
   localparam logic [7:0] CMD_PARAM_TEACH = 8'h04;
   localparam logic [7:0] CMD_OPDATA_TEACH = 8'h05;
   localparam logic [7:0] CMD_DIR_CHANGE = 8'h06;
   localparam logic [7:0] CMD_ENC_PRESET = 8'h07;
   localparam logic [7:0] CMD_TEACH_ARRAY = 8'h08;
   localparam logic [7:0] CMD_ERROR_CLEAR = 8'h09;
   localparam logic [7:0] CMD_STEP_SELECT = 8'h0A;

   // limits
   localparam logic [7:0] STEP_MIN = 8'h01;
   localparam logic [7:0] STEP_MAX = 8'h96;
   localparam logic [7:0] ARRAY_MIN = 8'h01;
   localparam logic [7:0] ARRAY_MAX = 8'h10;
   localparam logic [7:0] SEL_MAX = 8'h01;
   localparam logic [7:0] ENC_NUMBER = 8'h00;
   localparam logic [7:0] ITEM_COUNT = 8'h08;
   // upper bound of each teachable item, item 0 in the low word
   localparam logic [8*DATA_W-1:0] ITEM_MAX_TBL = {
      32'h0000FFFF, 32'h000003E8, 32'h00000064, 32'h0000FFFF,
      32'h000F4240, 32'h000F4240, 32'h00002710, 32'h00000096};

   // error codes (decimal in comments)
   localparam logic [CODE_W-1:0] ERR_NONE = 10'h000;
   localparam logic [CODE_W-1:0] ERR_ARRAY_COUNT = 10'h1CE; // 462
   localparam logic [CODE_W-1:0] ERR_SPEED_RUN = 10'h1CF; // 463
   localparam logic [CODE_W-1:0] ERR_ROM_RUN = 10'h1D0; // 464
   localparam logic [CODE_W-1:0] ERR_TEACH_STEP = 10'h1D1; // 465
   localparam logic [CODE_W-1:0] ERR_LIST = 10'h1D2; // 466
   localparam logic [CODE_W-1:0] ERR_METHOD = 10'h1D3; // 467
   localparam logic [CODE_W-1:0] ERR_PARAM_RUN = 10'h1D7; // 471
   localparam logic [CODE_W-1:0] ERR_OPDATA_RUN = 10'h1D8; // 472
   localparam logic [CODE_W-1:0] ERR_ITEM = 10'h1D9; // 473
   localparam logic [CODE_W-1:0] ERR_ITEM_RANGE = 10'h1DB; // 475
   localparam logic [CODE_W-1:0] ERR_ESTOP = 10'h1E1; // 481
   localparam logic [CODE_W-1:0] ERR_HARD_UP = 10'h1EC; // 492
   localparam logic [CODE_W-1:0] ERR_HARD_LO = 10'h1ED; // 493
   localparam logic [CODE_W-1:0] ERR_SOFT_UP = 10'h1F5; // 501
   localparam logic [CODE_W-1:0] ERR_SOFT_LO = 10'h1F6; // 502
   localparam logic [CODE_W-1:0] ERR_BAD_CMD = 10'h1FF; // 511
   localparam logic [CODE_W-1:0] ERR_AUX_STEP = 10'h200; // 512
   localparam logic [CODE_W-1:0] ERR_DIR_CONT = 10'h201; // 513
   localparam logic [CODE_W-1:0] ERR_ENC_NUM = 10'h213; // 531
   localparam logic [CODE_W-1:0] ERR_ENC_BUSY = 10'h214; // 532
   localparam logic [CODE_W-1:0] ERR_ENC_RANGE = 10'h216; // 534

   // fault flag positions
   localparam int F_ESTOP = 0;
   localparam int F_HARD_UP = 1;
   localparam int F_HARD_LO = 2;
   localparam int F_SOFT_UP = 3;
   localparam int F_SOFT_LO = 4;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [core/axcec_sync.sv]
`timescale 1ns/10ps
module axcec_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async,
   output logic [WIDTH-1:0] synced
);
   logic [WIDTH-1:0] stage;

   // first stage feeds the second only
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         stage <= '0;
         synced <= '0;
      end else begin
         stage <= async;
         synced <= stage;
      end
   end
endmodule

// [verification/axcec_prop_checker.sv]
`timescale 1ns/10ps
module axcec_prop_checker (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [axcec_pkg::DATA_W-1:0] rdata,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic estopIn,
   input wire logic [axcec_pkg::CODE_W-1:0] errCode,
   input wire logic errActive,
   input wire logic faultStop,
   input wire logic cmdAccept
);
   logic take;
   assign take = (wvalid && wready) || (awvalid && awready);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   chk_active_code: assert property (errActive == (errCode != 10'h000))
      else $error("error flag and code disagree");
   chk_accept_pulse: assert property (cmdAccept |=> !cmdAccept)
      else $error("accept pulse too long");
   chk_estop_code: assert property (estopIn [*4] |=> errCode == axcec_pkg::ERR_ESTOP)
      else $error("stop code missing");
   chk_fault_clear: assert property ($fell(faultStop) |-> $past(take, 2))
      else $error("fault dropped without clear");
   chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped");
   chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer dropped");
   chk_write_answer: assert property (take && wvalid && awvalid |=> bvalid && !wready)
      else $error("write answer late");
   chk_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read answer late");
   cov_accept: cover property (cmdAccept);
   cov_fault: cover property ($rose(faultStop));
   cov_bad_cmd: cover property (errCode == axcec_pkg::ERR_BAD_CMD);
endmodule
bind axcec_checker axcec_prop_checker chk (.clock, .rst_n, .awvalid, .awready, .wvalid, .wready,
   .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .estopIn, .errCode,
   .errActive, .faultStop, .cmdAccept);

// [verification/axcec_axis_model.sv]
`timescale 1ns/10ps
module axcec_axis_model (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [31:0] target,
   output logic running,
   output logic [31:0] position
);
   logic [31:0] next_position;
   // one count per cycle toward target, so a jog back out of a limit takes real time
   always_comb begin
      next_position = position;
      if ($signed(target) > $signed(position)) next_position = position + 32'h1;
      if ($signed(target) < $signed(position)) next_position = position - 32'h1;
   end
   always_ff @(posedge clock) position <= rst_n ? next_position : 32'h0;
   assign running = position != target;
endmodule

// [verification/axis_command_error_checker_tb.sv]
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
   $display("CHECK FAILED %0t got %h exp %h", $time, (a), (e)); end end
module axis_command_error_checker_tb;
   logic clock = 1'b0;
   logic rst_n, awvalid, wvalid, bready, arvalid, rready, contMode, curDirection, encAxisBusy;
   logic awready, wready, bvalid, arready, rvalid, errActive, faultStop, cmdAccept, axisRunning;
   logic [5:0] awaddr, araddr;
   logic [31:0] wdata, rdata, position, target, rdVal, seed;
   logic [1:0] bresp, rresp, rdResp;
   logic [9:0] errCode;
   logic [9:0] fc [3] = '{10'h1E1, 10'h1EC, 10'h1ED};
   logic [7:0] acceptedCmd, s, lastAcc = 8'h00;
   logic [2:0] pins;
   int miscompares = 0, check_count = 0, cyc = 0;
   always #12.5 clock = ~clock;
   axcec_checker dut (.clock, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .estopIn(pins[0]), .hardUpperIn(pins[1]), .hardLowerIn(pins[2]), .axisRunning,
      .contMode, .curDirection, .encAxisBusy, .position, .errCode, .errActive, .faultStop,
      .cmdAccept, .acceptedCmd);
   axcec_axis_model plant (.clock, .rst_n, .target, .running(axisRunning), .position);
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         miscompares++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [9:0] step_code(input logic [7:0] n);
      return (n >= 8'h01 && n <= 8'h96) ? 10'h000 : 10'h200;
   endfunction
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) bready <= !bready;
      end while (!(bvalid && bready));
   endtask
   task automatic rd(input logic [5:0] a);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
         if (rvalid) rready <= !rready;
      end while (!(rvalid && rready));
      rdVal = rdata;
      rdResp = rresp;
   endtask
   task automatic clr();
      wr(axcec_pkg::REG_CMD, 32'h9);
      repeat (3) @(posedge clock);
   endtask
   task automatic cc(input logic [7:0] c, input logic [8:0] a, input logic [31:0] sl, v,
         input logic [9:0] e);
      clr();
      wr(axcec_pkg::REG_ARG, {23'h0, a});
      wr(axcec_pkg::REG_SEL, sl);
      wr(axcec_pkg::REG_VALUE, v);
      wr(axcec_pkg::REG_CMD, {24'h0, c});
      repeat (3) @(posedge clock);
      `CHK(errCode, e)
      if (e == 10'h000) lastAcc = c;
      `CHK(acceptedCmd, lastAcc)
   endtask
   initial begin
      {rst_n, awvalid, wvalid, bready, arvalid, rready, contMode, curDirection} = 8'h00;
      {encAxisBusy, pins, awaddr, araddr, wdata, target} = 80'h0;
      seed = 32'hC375;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      rd(axcec_pkg::REG_SOFT_UP);
      `CHK(rdVal, 32'h7FFFFFFF)
      cc(8'h01, 9'h097, 32'h0, 32'h0, 10'h1D1);
      cc(8'h02, 9'h096, 32'h0, 32'h0, 10'h000);
      cc(8'h03, 9'h001, 32'h2, 32'h0, 10'h1D2);
      cc(8'h03, 9'h001, 32'h200, 32'h0, 10'h1D3);
      cc(8'h03, 9'h001, 32'h101, 32'h0, 10'h000);
      cc(8'h04, 9'h000, 32'h80000, 32'h0, 10'h1D9);
      cc(8'h05, 9'h000, 32'h0, 32'h97, 10'h1DB);
      cc(8'h05, 9'h000, 32'h0, 32'h96, 10'h000);
      cc(8'h0B, 9'h000, 32'h0, 32'h0, 10'h1FF);
      cc(8'h07, 9'h001, 32'h0, 32'h0, 10'h213);
      rd(axcec_pkg::REG_ERROR);
      `CHK(rdVal[9:0], 10'h213)
      rd(6'h28);
      `CHK({rdResp, rdVal}, {2'h2, 32'h0})
      cc(8'h08, 9'h000, 32'h11000000, 32'h0, 10'h1CE);
      cc(8'h08, 9'h000, 32'h10000000, 32'h0, 10'h000);
      encAxisBusy <= 1'b1;
      cc(8'h07, 9'h000, 32'h0, 32'h0, 10'h214);
      encAxisBusy <= 1'b0;
      wr(axcec_pkg::REG_ENC_MAX, 32'h64);
      cc(8'h07, 9'h000, 32'h0, 32'h65, 10'h216);
      cc(8'h07, 9'h000, 32'h0, 32'h64, 10'h000);
      contMode <= 1'b1;
      cc(8'h06, 9'h101, 32'h0, 32'h0, 10'h201);
      cc(8'h06, 9'h001, 32'h0, 32'h0, 10'h000);
      contMode <= 1'b0;
      for (int i = 0; i < 24; i++) begin
         seed = xs();
         s = i == 0 ? 8'h00 : i == 1 ? 8'h96 : i == 2 ? 8'h97 : seed[7:0];
         cc(i[0] ? 8'h0A : 8'h06, {1'b0, s}, seed, 32'h0, step_code(s));
      end
      for (int i = 0; i < 3; i++) begin
         pins <= 3'h1 << i;
         repeat (6) @(posedge clock);
         `CHK(errCode, fc[i])
         clr();
         `CHK(faultStop, 1'b1)
         pins <= 3'h0;
         clr();
         `CHK(errCode, 10'h000)
      end
      wr(axcec_pkg::REG_SOFT_UP, 32'h64);
      wr(axcec_pkg::REG_SOFT_LO, 32'hFFFFFF9C);
      for (int i = 0; i < 2; i++) begin
         target <= i ? 32'hFFFFFF80 : 32'h80;
         repeat (150) @(posedge clock);
         clr();
         `CHK(errCode, i ? 10'h1F6 : 10'h1F5)
         target <= 32'h0;
         repeat (150) @(posedge clock);
         clr();
         `CHK(errCode, 10'h000)
      end
      wr(axcec_pkg::REG_SOFT_UP, 32'h7FFFFFFF);
      target <= 32'h1000;
      cc(8'h01, 9'h001, 32'h0, 32'h0, 10'h1CF);
      cc(8'h02, 9'h001, 32'h0, 32'h0, 10'h1D0);
      cc(8'h04, 9'h001, 32'h0, 32'h0, 10'h1D7);
      cc(8'h05, 9'h001, 32'h0, 32'h0, 10'h1D8);
      end_of_test();
   end
endmodule
